// file: rtl/astx_pkg.sv
// ****************************************************************
// Shared constants and types of the asynchronous serial transceiver
// ****************************************************************
package astx_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ASTX_IDX_BAUD = 3'h0; // Baud divisor
  localparam logic [2:0] ASTX_IDX_TRANSMIT_STATUS_CONTROL = 3'h1; // Transmit status/control
  localparam logic [2:0] ASTX_IDX_RECEIVE_STATUS_CONTROL = 3'h2; // Receive status/control
  localparam logic [2:0] ASTX_IDX_TXBUF = 3'h3; // Transmit buffer
  localparam logic [2:0] ASTX_IDX_RCBUF = 3'h4; // Receive buffer
  localparam logic [2:0] ASTX_IDX_FLAGS = 3'h5; // Peripheral flags 1
  localparam logic [2:0] ASTX_IDX_ENABLES = 3'h6; // Peripheral enables 1

  // Transmit status/control field positions
  localparam int ASTX_TX_CSRC = 7; // Clock source (stored only)
  localparam int ASTX_TX_NINE = 6; // Nine-bit transmit select
  localparam int ASTX_TX_EN = 5; // Transmit enable
  localparam int ASTX_TX_SYNC = 4; // Synchronous mode select
  localparam int ASTX_TX_HIGH_SPEED_SELECT = 2; // High speed select
  localparam int ASTX_TX_TX_SHIFTER_EMPTY = 1; // Shifter empty, read only
  localparam int ASTX_TX_NINTH = 0; // Ninth transmit bit

  // Receive status/control field positions
  localparam int ASTX_RC_PORT_ENABLE = 7; // Port enable
  localparam int ASTX_RC_NINE = 6; // Nine-bit receive select
  localparam int ASTX_RC_SREN = 5; // Single receive (stored only)
  localparam int ASTX_RC_CONTINUOUS_RX_ENABLE = 4; // Continuous receive enable
  localparam int ASTX_RC_FRAMING_ERROR_FLAG = 2; // Framing error, read only
  localparam int ASTX_RC_OVERRUN_ERROR_FLAG = 1; // Overrun error, read only
  localparam int ASTX_RC_NINTH = 0; // Received ninth bit, read only

  // Peripheral flag and enable field positions
  localparam int ASTX_PF_RX = 5; // Receive complete
  localparam int ASTX_PF_TX = 4; // Transmit buffer empty

  // Values after reset
  localparam logic [7:0] ASTX_TRANSMIT_STATUS_CONTROL_RESET = 8'h02;
  localparam logic [7:0] ASTX_REG_RESET = 8'h00;

  // Bit timing counts in baud ticks
  localparam logic [3:0] ASTX_TICKS_LAST = 4'hf; // Sixteen ticks per bit
  localparam logic [3:0] ASTX_TICKS_MID = 4'h7; // Middle of start bit
  localparam logic [3:0] ASTX_LAST_BIT8 = 4'h7; // Last index, eight bits
  localparam logic [3:0] ASTX_LAST_BIT9 = 4'h8; // Last index, nine bits
  localparam logic [1:0] ASTX_PRE_LAST = 2'h3; // Low speed prescale

  // Transmitter and receiver sequencer states
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} astx_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} astx_rx_state_t;

  // One request on the register port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } astx_bus_req_t;

  // All state of the transceiver
  typedef struct packed {
    logic [7:0] divisor;
    logic high_speed_select, sync, tx_enable, tx9, tx_ninth_bit, csrc;
    logic port_enable, rx9, sren, continuous_rx_enable;
    logic [7:0] pie;
    logic [7:0] txbuf;
    logic txbuf_full, tx_buffer_empty_flag;
    astx_tx_state_t tx_state;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt, tx_bit;
    logic tx_line;
    logic [7:0] brg_cnt;
    logic [1:0] pre_cnt;
    logic rx_s1, rx_s2, rx_s3, rx_line;
    astx_rx_state_t rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt, rx_bit;
    logic [7:0] rcbuf;
    logic rx_ninth_bit, framing_error_flag, overrun_error_flag, rx_complete_flag;
    logic [7:0] rd_data;
    logic tx_irq, rx_irq;
  } astx_state_t;

endpackage

// file: rtl/astx_transceiver.sv
// Function
// - Start, eight or nine data, one stop
// - Eight-bit divisor register sets bit timing
// - Data bits travel least significant first
// - Independent directions and data lengths, shared framing and rate
// - High speed select picks x16 or x64
// - No hardware parity; ninth bit carries it
// - Sleep halts all transmit and receive
// - Synchronous select clear means asynchronous mode
// - Shifter reloads only after stop, then immediately
// - Buffer-to-shifter move sets buffer-empty flag
// - Buffer-empty flag ignores clears; buffer write clears
// - Read-only shifter-empty bit, no interrupt
// - Transmit shifter has no register address
// - Setting transmit enable sets buffer-empty flag
// - Ninth transmit bit comes from its field
// - Buffer write after enable starts transmission
// - Receiver samples pin at sixteen per bit
// - Each received character sets receive-complete flag
// - Low eight received bits read from buffer
// - Clearing continuous receive clears overrun error
`timescale 1ns/1ps
`default_nettype none

module astx_transceiver import astx_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire astx_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // Power state
  input wire logic sleep,
  // Serial pins
  input wire logic receive_pin,
  output logic transmit_pin,
  // Flag requests towards the interrupt controller
  output logic tx_irq,
  output logic rx_irq
);

  // ****************************************************************
  // State and decode
  // ****************************************************************
  astx_state_t st_reg; // Every flip-flop of the block outside the checks
  astx_state_t st_next; // Next value of the whole state
  logic tick; // One baud tick, sixteen per bit
  logic async_on; // Port enabled in asynchronous mode
  logic rx_done; // A character has just finished
  logic rx_keep; // Receive buffer is free for it
  logic rd_rcbuf; // Software reads the receive buffer
  logic [3:0] tx_last; // Last data bit index of transmit
  logic [3:0] rx_last; // Last data bit index of receive
  logic [7:0] transmit_status_control_view; // Transmit status/control as read
  logic [7:0] receive_status_control_view; // Receive status/control as read

  assign rd_data = st_reg.rd_data;
  assign transmit_pin = st_reg.tx_line;
  assign tx_irq = st_reg.tx_irq;
  assign rx_irq = st_reg.rx_irq;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Order matters: reads before the receiver so a completion in the read cycle is kept,
  // engines next, register writes last so software has the final word.
  always_comb begin
    st_next = st_reg;
    st_next.rd_data = 8'h00;
    tick = 1'b0;
    rx_done = 1'b0;
    async_on = st_reg.port_enable & ~st_reg.sync;
    rd_rcbuf = bus_req.rd && (bus_req.addr == ASTX_IDX_RCBUF);
    rx_keep = ~st_reg.rx_complete_flag | rd_rcbuf;
    tx_last = st_reg.tx9 ? ASTX_LAST_BIT9 : ASTX_LAST_BIT8;
    rx_last = st_reg.rx9 ? ASTX_LAST_BIT9 : ASTX_LAST_BIT8;
    // Shifter empty is live state, never a stored bit
    transmit_status_control_view = {st_reg.csrc, st_reg.tx9, st_reg.tx_enable, st_reg.sync, 1'b0,
                  st_reg.high_speed_select, st_reg.tx_state == TX_IDLE, st_reg.tx_ninth_bit};
    receive_status_control_view = {st_reg.port_enable, st_reg.rx9, st_reg.sren, st_reg.continuous_rx_enable, 1'b0,
                  st_reg.framing_error_flag, st_reg.overrun_error_flag, st_reg.rx_ninth_bit};

    // Baud generator: divisor+1 clocks per tick, four times that at low speed
    if (!async_on) begin
      st_next.brg_cnt = 8'h00;
      st_next.pre_cnt = 2'h0;
    end else if (!sleep) begin
      if (st_reg.brg_cnt == 8'h00) begin
        st_next.brg_cnt = st_reg.divisor;
        st_next.pre_cnt = st_reg.pre_cnt + 2'h1;
        tick = st_reg.high_speed_select | (st_reg.pre_cnt == ASTX_PRE_LAST);
      end else begin
        st_next.brg_cnt = st_reg.brg_cnt - 8'h01;
      end
    end

    // Pin synchroniser; the filtered level moves once stages two and three agree
    st_next.rx_s1 = receive_pin;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.rx_s3 = st_reg.rx_s2;
    if (st_reg.rx_s2 == st_reg.rx_s3) begin
      st_next.rx_line = st_reg.rx_s3;
    end

    // Register reads, with their side effects
    if (bus_req.rd) begin
      case (bus_req.addr)
        ASTX_IDX_BAUD: st_next.rd_data = st_reg.divisor;
        ASTX_IDX_TRANSMIT_STATUS_CONTROL: st_next.rd_data = transmit_status_control_view;
        ASTX_IDX_RECEIVE_STATUS_CONTROL: st_next.rd_data = receive_status_control_view;
        ASTX_IDX_TXBUF: st_next.rd_data = st_reg.txbuf;
        ASTX_IDX_RCBUF: begin
          st_next.rd_data = st_reg.rcbuf;
          st_next.rx_complete_flag = 1'b0;
        end
        ASTX_IDX_FLAGS: begin
          st_next.rd_data = 8'h00;
          st_next.rd_data[ASTX_PF_RX] = st_reg.rx_complete_flag;
          st_next.rd_data[ASTX_PF_TX] = st_reg.tx_buffer_empty_flag;
        end
        ASTX_IDX_ENABLES: st_next.rd_data = st_reg.pie;
        default: st_next.rd_data = 8'h00; // Unmapped reads as zero
      endcase
    end

    // Receiver: 16x oversampling sequencer, runs apart from the transmitter
    if (!async_on || !st_reg.continuous_rx_enable) begin
      st_next.rx_state = RX_IDLE;
      st_next.overrun_error_flag = 1'b0;
    end else if (!sleep && tick && !st_reg.overrun_error_flag) begin
      // An overrun freezes reception until continuous receive is cleared
      st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
      case (st_reg.rx_state)
        RX_IDLE: begin
          // A low line seen on a tick while idle marks a start bit
          if (!st_reg.rx_line) begin
            st_next.rx_state = RX_START;
            st_next.rx_cnt = 4'h0;
          end
        end
        RX_START: begin
          // Recheck mid start bit so a glitch is not taken as a frame
          if (st_reg.rx_cnt == ASTX_TICKS_MID) begin
            st_next.rx_cnt = 4'h0;
            st_next.rx_bit = 4'h0;
            st_next.rx_state = st_reg.rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (st_reg.rx_cnt == ASTX_TICKS_LAST) begin
            st_next.rx_shift = {st_reg.rx_line, st_reg.rx_shift[8:1]};
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == rx_last) begin
              st_next.rx_state = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (st_reg.rx_cnt == ASTX_TICKS_LAST) begin
            st_next.rx_state = RX_IDLE;
            rx_done = 1'b1;
          end
        end
        default: st_next.rx_state = RX_IDLE;
      endcase
    end

    // Character complete: deliver it, or flag overrun if still unread
    if (rx_done) begin
      if (rx_keep) begin
        st_next.rcbuf = st_reg.rx9 ? st_reg.rx_shift[7:0] : st_reg.rx_shift[8:1];
        st_next.rx_ninth_bit = st_reg.rx9 & st_reg.rx_shift[8];
        st_next.framing_error_flag = ~st_reg.rx_line;
        st_next.rx_complete_flag = 1'b1;
      end else begin
        st_next.overrun_error_flag = 1'b1;
      end
    end

    // Transmitter: buffer feeds the shifter only when the shifter is idle
    if (!async_on || !st_reg.tx_enable) begin
      st_next.tx_state = TX_IDLE;
      st_next.tx_line = 1'b1;
    end else if (st_reg.tx_state == TX_IDLE) begin
      // Loads in the cycle after the stop bit ends, if a character waits
      if (st_reg.txbuf_full && !sleep) begin
        st_next.tx_shift = {st_reg.tx_ninth_bit, st_reg.txbuf};
        st_next.txbuf_full = 1'b0;
        st_next.tx_buffer_empty_flag = 1'b1;
        st_next.tx_state = TX_START;
        st_next.tx_cnt = 4'h0;
        st_next.tx_line = 1'b0;
      end
    end else if (!sleep && tick) begin
      st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
      if (st_reg.tx_cnt == ASTX_TICKS_LAST) begin
        case (st_reg.tx_state)
          TX_START: begin
            st_next.tx_state = TX_DATA;
            st_next.tx_bit = 4'h0;
            st_next.tx_line = st_reg.tx_shift[0];
          end
          TX_DATA: begin
            if (st_reg.tx_bit == tx_last) begin
              st_next.tx_state = TX_STOP;
              st_next.tx_line = 1'b1;
            end else begin
              st_next.tx_bit = st_reg.tx_bit + 4'h1;
              st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
              st_next.tx_line = st_reg.tx_shift[1];
            end
          end
          TX_STOP: st_next.tx_state = TX_IDLE;
          default: st_next.tx_state = TX_IDLE;
        endcase
      end
    end

    // Register writes; the shifter itself has no address
    if (bus_req.wr) begin
      case (bus_req.addr)
        ASTX_IDX_BAUD: st_next.divisor = bus_req.wdata;
        ASTX_IDX_TRANSMIT_STATUS_CONTROL: begin
          st_next.csrc = bus_req.wdata[ASTX_TX_CSRC];
          st_next.tx9 = bus_req.wdata[ASTX_TX_NINE];
          st_next.tx_enable = bus_req.wdata[ASTX_TX_EN];
          st_next.sync = bus_req.wdata[ASTX_TX_SYNC];
          st_next.high_speed_select = bus_req.wdata[ASTX_TX_HIGH_SPEED_SELECT];
          st_next.tx_ninth_bit = bus_req.wdata[ASTX_TX_NINTH];
          if (bus_req.wdata[ASTX_TX_EN] && !st_reg.tx_enable) begin
            st_next.tx_buffer_empty_flag = 1'b1;
          end
        end
        ASTX_IDX_RECEIVE_STATUS_CONTROL: begin
          st_next.port_enable = bus_req.wdata[ASTX_RC_PORT_ENABLE];
          st_next.rx9 = bus_req.wdata[ASTX_RC_NINE];
          st_next.sren = bus_req.wdata[ASTX_RC_SREN];
          st_next.continuous_rx_enable = bus_req.wdata[ASTX_RC_CONTINUOUS_RX_ENABLE];
          if (!bus_req.wdata[ASTX_RC_CONTINUOUS_RX_ENABLE]) begin
            st_next.overrun_error_flag = 1'b0;
          end
        end
        ASTX_IDX_TXBUF: begin
          // New data makes the buffer full again, so the flag drops
          st_next.txbuf = bus_req.wdata;
          st_next.txbuf_full = 1'b1;
          st_next.tx_buffer_empty_flag = 1'b0;
        end
        ASTX_IDX_ENABLES: st_next.pie = bus_req.wdata;
        default: st_next.pie = st_next.pie; // Flags are read only
      endcase
    end

    // Flag requests follow the flags and their enables
    st_next.tx_irq = st_next.tx_buffer_empty_flag & st_next.pie[ASTX_PF_TX];
    st_next.rx_irq = st_next.rx_complete_flag & st_next.pie[ASTX_PF_RX];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Idle lines and the synchroniser reset high so no false start is seen
  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.tx_line <= 1'b1;
      st_reg.rx_s1 <= 1'b1;
      st_reg.rx_s2 <= 1'b1;
      st_reg.rx_s3 <= 1'b1;
      st_reg.rx_line <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [10:0] gap_cnt; // Clocks since the last tick
  logic gap_ok; // Settings unchanged since the last tick
  logic [10:0] gap_want; // Expected clocks between ticks

  assign gap_want = (11'(st_reg.divisor) + 11'h001) * (st_reg.high_speed_select ? 11'h001 : 11'h004);

  // Measures tick spacing while the rate settings stand still
  always_ff @(posedge clock) begin
    if (reset || sleep || !async_on || (bus_req.wr && bus_req.addr <= ASTX_IDX_TRANSMIT_STATUS_CONTROL)) begin
      gap_cnt <= 11'h000;
      gap_ok <= 1'b0;
    end else if (tick) begin
      gap_cnt <= 11'h001;
      gap_ok <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 11'h001;
    end
  end

  a_baud_tick_gap: assert property (@(posedge clock) disable iff (reset)
    tick && gap_ok && gap_cnt != 11'h000 |-> gap_cnt == gap_want)
    else $error("baud tick spacing wrong");
  a_txbuf_write_clears: assert property (@(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == ASTX_IDX_TXBUF |=> !st_reg.tx_buffer_empty_flag && st_reg.txbuf_full)
    else $error("buffer write did not clear empty flag");
  a_tx_buffer_empty_flag_no_sw_clear: assert property (@(posedge clock) disable iff (reset)
    st_reg.tx_buffer_empty_flag && !(bus_req.wr && bus_req.addr == ASTX_IDX_TXBUF) |=> st_reg.tx_buffer_empty_flag)
    else $error("empty flag dropped without a buffer write");
  a_tx_enable_sets_flag: assert property (@(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == ASTX_IDX_TRANSMIT_STATUS_CONTROL && bus_req.wdata[ASTX_TX_EN] && !st_reg.tx_enable
      |=> st_reg.tx_buffer_empty_flag)
    else $error("enable did not set empty flag");
  a_load_sets_flag: assert property (@(posedge clock) disable iff (reset)
    st_reg.tx_state == TX_IDLE && st_reg.txbuf_full && async_on && st_reg.tx_enable && !sleep
      && !bus_req.wr |=> st_reg.tx_state == TX_START && st_reg.tx_buffer_empty_flag)
    else $error("shifter load did not set empty flag");
  a_start_low_stop_high: assert property (@(posedge clock) disable iff (reset)
    (st_reg.tx_state == TX_START |-> !transmit_pin)
      and (st_reg.tx_state == TX_STOP |-> transmit_pin))
    else $error("start or stop level wrong on line");
  a_sleep_freezes: assert property (@(posedge clock) disable iff (reset)
    sleep && !bus_req.wr |=> $stable(st_reg.tx_state) && $stable(st_reg.rx_state))
    else $error("activity during sleep");
  a_rx_complete_flag: assert property (@(posedge clock) disable iff (reset)
    rx_done && rx_keep && !bus_req.wr |=> st_reg.rx_complete_flag && rx_irq == st_reg.pie[ASTX_PF_RX])
    else $error("completion did not set receive flag");
  a_overrun_flag: assert property (@(posedge clock) disable iff (reset)
    rx_done && !rx_keep && !bus_req.wr |=> st_reg.overrun_error_flag [*2])
    else $error("overrun not flagged");
  a_continuous_rx_enable_clears_err: assert property (@(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == ASTX_IDX_RECEIVE_STATUS_CONTROL && !bus_req.wdata[ASTX_RC_CONTINUOUS_RX_ENABLE]
      |=> !st_reg.overrun_error_flag)
    else $error("clearing receive enable kept overrun");

endmodule // astx_transceiver

`default_nettype wire

// file: sim/astx_remote.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Remote serial device facing the transceiver's pins
// ****************************************************************
module astx_remote (
  // Clock
  input wire logic clock,
  // Line format
  input wire logic [7:0] bit_clocks, // Clocks per bit
  input wire logic nine, // Nine data bits
  // Serial lines
  input wire logic line_in, // From the transmit pin
  output logic line_out, // To the receive pin
  // Received character
  output logic got_valid,
  output logic [8:0] got_data,
  output logic got_stop
);
  logic [8:0] shift_in; // Bits gathered so far
  int k; // Bit index of the receiver

  // Idle line is high, as on a pulled-up wire
  initial begin
    line_out = 1'b1;
    got_valid = 1'b0;
    got_data = 9'h000;
    got_stop = 1'b0;
  end

  // Frame receiver: mid-bit sampling, data LSB first
  initial forever begin
    @(negedge line_in);
    repeat (bit_clocks / 2) @(posedge clock);
    if (line_in == 1'b0) begin // Start confirmed
      shift_in = 9'h000;
      for (k = 0; k < (nine ? 9 : 8); k++) begin // LSB first
        repeat (bit_clocks) @(posedge clock);
        shift_in[k] = line_in;
      end
      repeat (bit_clocks) @(posedge clock);
      got_stop <= line_in; // One stop bit
      got_data <= shift_in;
      got_valid <= 1'b1;
      @(posedge clock);
      got_valid <= 1'b0;
    end
  end

  // Send one frame; a low stop level makes a broken frame on purpose
  task automatic send(input logic [8:0] ch, input logic stop_lvl);
    int j;
    line_out <= 1'b0; // Start bit
    repeat (bit_clocks) @(posedge clock);
    for (j = 0; j < (nine ? 9 : 8); j++) begin // LSB first
      line_out <= ch[j];
      repeat (bit_clocks) @(posedge clock);
    end
    line_out <= stop_lvl; // Stop bit
    repeat (bit_clocks) @(posedge clock);
    line_out <= 1'b1; // Idle gap of one bit
    repeat (bit_clocks) @(posedge clock);
  endtask
endmodule // astx_remote

`default_nettype wire

// file: sim/astx_transceiver_tb.sv
`timescale 1ns/1ps
`default_nettype none

module astx_transceiver_tb import astx_pkg::*;;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock, reset, sleep, transmit_pin, receive_pin, tx_irq, rx_irq;
  astx_bus_req_t bus_req;
  logic [7:0] rd_data, r, bit_clk;
  logic nine, got_valid, got_stop, rd_prev;
  logic [8:0] got_data;
  logic [15:0] exp_rd[$]; // Mask and value of each pending read
  logic [15:0] pend; // Oldest pending read note, taken off the queue
  logic [8:0] exp_ser[$]; // Characters the remote should see
  int mismatches, checks_done, seed, n;

  astx_transceiver uut (.clock(clock), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .sleep(sleep), .receive_pin(receive_pin),
    .transmit_pin(transmit_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
  astx_remote remote (.clock(clock), .bit_clocks(bit_clk), .nine(nine),
    .line_in(transmit_pin), .line_out(receive_pin), .got_valid(got_valid),
    .got_data(got_data), .got_stop(got_stop));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up;
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One strobe cycle, then idle; the next call leaves a gap cycle
  task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{a, d, w, ~w};
    @(posedge clock);
    bus_req <= '{3'h0, 8'h00, 1'b0, 1'b0};
  endtask

  task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_rd.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask

  // Bounded wait until the remote has seen every character
  task wait_ser;
    for (n = 0; n < 4000 && exp_ser.size() > 0; n++) @(posedge clock);
    chk(9'(exp_ser.size()), 9'h000);
  endtask

  task tx_char(input logic [8:0] c);
    exp_ser.push_back(c);
    bus(1'b1, ASTX_IDX_TXBUF, c[7:0]);
  endtask

  // ****************************************************************
  // Result watchers: read data one cycle after the strobe, frames
  // ****************************************************************
  always @(posedge clock) begin
    if (rd_prev === 1'b1) begin
      pend = exp_rd.pop_front();
      chk({1'b0, rd_data & pend[15:8]}, {1'b0, pend[7:0] & pend[15:8]});
    end
    rd_prev <= bus_req.rd;
    if (got_valid === 1'b1) begin
      chk(got_data, exp_ser.size() > 0 ? exp_ser.pop_front() : 9'h1ff);
      chk({8'h00, got_stop}, 9'h001);
    end
  end

  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    mismatches++;
    wrap_up;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    sleep = 1'b0;
    bus_req = '{3'h0, 8'h00, 1'b0, 1'b0};
    rd_prev = 1'b0;
    bit_clk = 8'h20;
    nine = 1'b0;
    seed = 41;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    // Reset values; index 7 is unmapped and reads zero
    for (n = 0; n < 8; n++) rd(3'(n), n == 1 ? 8'h02 : 8'h00, 8'hff);
    // Divisor 1 at x16 gives 32 clocks a bit
    bus(1'b1, ASTX_IDX_BAUD, 8'h01);
    bus(1'b1, ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h04);
    bus(1'b1, ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h90);
    bus(1'b1, ASTX_IDX_ENABLES, 8'h30);
    rd(ASTX_IDX_FLAGS, 8'h00, 8'h10);
    bus(1'b1, ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h24);
    rd(ASTX_IDX_FLAGS, 8'h10, 8'h10);
    rd(ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h26, 8'hff);
    rd(ASTX_IDX_BAUD, 8'h01, 8'hff);
    chk({8'h00, tx_irq}, 9'h001);
    // Back to back characters, then a write to the read-only flags register
    r = 8'($random(seed));
    tx_char({1'b0, r});
    rd(ASTX_IDX_FLAGS, 8'h10, 8'h10);
    tx_char({1'b0, ~r});
    rd(ASTX_IDX_FLAGS, 8'h00, 8'h10);
    bus(1'b1, ASTX_IDX_FLAGS, 8'h10);
    rd(ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h00, 8'h02);
    wait_ser;
    repeat (64) @(posedge clock);
    rd(ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h02);
    // Ninth bit from its field
    nine = 1'b1;
    bus(1'b1, ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h65);
    tx_char({1'b1, 8'($random(seed))});
    wait_ser;
    repeat (64) @(posedge clock);
    nine = 1'b0;
    // Sleep holds the transmitter still
    sleep <= 1'b1;
    bus(1'b1, ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h24);
    r = 8'($random(seed));
    bus(1'b1, ASTX_IDX_TXBUF, r);
    repeat (500) @(posedge clock);
    exp_ser.push_back({1'b0, r});
    sleep <= 1'b0;
    wait_ser;
    repeat (64) @(posedge clock);
    // x64 rate with divisor 0 gives 64 clocks a bit
    bus(1'b1, ASTX_IDX_BAUD, 8'h00);
    bus(1'b1, ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h20);
    bit_clk = 8'h40;
    tx_char({1'b0, 8'($random(seed))});
    wait_ser;
    repeat (128) @(posedge clock);
    bus(1'b1, ASTX_IDX_BAUD, 8'h01);
    bus(1'b1, ASTX_IDX_TRANSMIT_STATUS_CONTROL, 8'h24);
    bit_clk = 8'h20;
    // Reception: status before data, read clears the flag
    r = 8'($random(seed));
    remote.send({1'b0, r}, 1'b1);
    for (n = 0; n < 200 && rx_irq !== 1'b1; n++) @(posedge clock);
    chk({8'h00, rx_irq}, 9'h001);
    rd(ASTX_IDX_FLAGS, 8'h20, 8'h20);
    rd(ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h90, 8'hfe);
    rd(ASTX_IDX_RCBUF, r, 8'hff);
    rd(ASTX_IDX_FLAGS, 8'h00, 8'h20);
    // Overrun: second character with the first unread
    remote.send({1'b0, ~r}, 1'b1);
    remote.send({1'b0, r}, 1'b1);
    repeat (40) @(posedge clock);
    rd(ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h92, 8'hfe);
    bus(1'b1, ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    rd(ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h80, 8'hfe);
    rd(ASTX_IDX_RCBUF, ~r, 8'hff);
    // Framing error on a low stop bit
    bus(1'b1, ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h90);
    remote.send({1'b0, r}, 1'b0);
    rd(ASTX_IDX_RECEIVE_STATUS_CONTROL, 8'h94, 8'hfe);
    rd(ASTX_IDX_RCBUF, r, 8'hff);
    repeat (8) @(posedge clock);
    wrap_up;
  end
endmodule // astx_transceiver_tb

`default_nettype wire
